// file: hdl/lsr_map.svh
`ifndef LSR_MAP_SVH
`define LSR_MAP_SVH
// Register indices; byte address is four times the index
`define LSR_IDX_MOD_DRIVE   6'h15
`define LSR_IDX_FAULT_STAT  6'h16
`define LSR_IDX_RELEASE     6'h17
`define LSR_IDX_GAIN_TAP    6'h18
`define LSR_IDX_LOS_CTRL    6'h20
`define LSR_IDX_ASSERT_LVL  6'h21
`define LSR_IDX_IRQ_STAT    6'h22
`define LSR_IDX_IRQ_MASK    6'h23
// Status byte fields
`define LSR_ST_RSVD         7
`define LSR_ST_LASER_EN     6
`define LSR_ST_RX_FLT       5
`define LSR_ST_INT          4
`define LSR_ST_APC_SAT      3
`define LSR_ST_BIAS_FLT     2
`define LSR_ST_TX_FLT       1
`define LSR_ST_RATE_SEL     0
// Gain tap field and scaling
`define LSR_TAP_W           5
`define LSR_TAP_FULL        6'h20
`define LSR_TAP_SHIFT       5
`define LSR_LOS_DIS_BIT     0
// Event count and reset values
`define LSR_NUM_EV          5
`define LSR_RST_BYTE        8'h00
`define LSR_RST_EV          5'h00
`endif

// file: hdl/lsr_pkg.sv
`default_nettype none
package lsr_pkg;
  // Registered fault comparator and loop states from the core
  typedef struct packed {
    logic rx_power;
    logic bias_current;
    logic tx_power;
    logic loop_saturation;
  } lsr_faults_t;

  // Sticky event positions in the interrupt status register
  typedef enum logic [2:0] {
    LSR_EV_LOS   = 3'b000,
    LSR_EV_RXF   = 3'b001,
    LSR_EV_BIAS  = 3'b010,
    LSR_EV_TXF   = 3'b011,
    LSR_EV_APC   = 3'b100
  } lsr_event_t;
endpackage
`default_nettype wire

// file: hdl/lsr_regs.sv
// What this block does
// - Modulation readback returns the compensated value now driving the modulation DAC.
// - Group registers need a valid OEM password; otherwise access is refused.
// - Status bit 7 is reserved and always reads zero.
// - Status bit 6 shows laser enable: zero while disabled, one when allowed.
// - Status bit 5 shows the registered receive power fault.
// - Status bit 4 shows the interrupt output, active high.
// - Status bit 3 shows the registered power loop saturation fault.
// - Status bit 2 shows the registered bias current fault.
// - Status bit 1 shows the registered transmit power fault.
// - Status bit 0 shows the rate select pin level after its two-flop synchroniser.
// - Loss output asserts when scaled receive power falls below assert level.
// - Loss output releases when scaled power rises above release level, or when loss disable is set.
// - Receive power is scaled by the gain tap before comparing.
// - With loss disable set, the release level is ignored.
// - Release level and gain tap are reloaded from the stored image on every reset.
// - Gain tap zero passes input; other codes scale by (32-code)/32.
// - With loss disable set, the receive power fault sets no interrupt status bit and output is held low.
//
// The Wishbone register port was chosen for this implementation.
`include "lsr_map.svh"
`default_nettype none

module lsr_regs #(
  parameter int unsigned DW = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Core side
  input  wire logic                  oem_access_ok,
  input  wire logic [DW-1:0]         modulation_drive_value,
  input  wire logic                  laser_enable,
  input  wire lsr_pkg::lsr_faults_t  faults,
  input  wire logic                  rate_select_output,
  input  wire logic [DW-1:0]         receive_power_input,
  input  wire logic [DW-1:0]         nv_release_image,
  input  wire logic [`LSR_TAP_W-1:0] nv_gain_image,
  output logic                       nv_store,
  output logic                       signal_loss_output,
  output logic                       irq
);

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic [5:0] reg_index(input logic [7:0] adr);
    reg_index = adr[7:2];
  endfunction

  function automatic logic in_group(input logic [5:0] idx);
    in_group = (idx >= `LSR_IDX_MOD_DRIVE) && (idx <= `LSR_IDX_GAIN_TAP);
  endfunction

  logic [5:0] idx;
  logic       req;
  logic       wr;
  logic       grp_ok;

  assign idx    = reg_index(wb_adr_i);
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i && wb_sel_i[0];
  assign grp_ok = !in_group(idx) || oem_access_ok;

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  // The rate select level is read back from its pin
  logic rsel_meta_q;
  logic rsel_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rsel_meta_q <= 1'b0;
      rsel_q      <= 1'b0;
    end
    else
    begin
      rsel_meta_q <= rate_select_output;
      rsel_q      <= rsel_meta_q;
    end
  end

  // ==========================================================
  // Non-volatile settings
  // ==========================================================
  logic [DW-1:0]         release_q;
  logic [`LSR_TAP_W-1:0] gain_tap_q;
  logic                  nv_store_q;

  // Reloaded from the stored image during reset, so resets never lose them
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      release_q  <= nv_release_image;
      gain_tap_q <= nv_gain_image;
    end
    else if (wr && grp_ok)
    begin
      if (idx == `LSR_IDX_RELEASE)
      begin
        release_q <= wb_dat_i[DW-1:0];
      end
      if (idx == `LSR_IDX_GAIN_TAP)
      begin
        // Reserved upper bits are dropped
        gain_tap_q <= wb_dat_i[`LSR_TAP_W-1:0];
      end
    end
  end

  // Tells the store to commit the new values
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      nv_store_q <= 1'b0;
    end
    else
    begin
      nv_store_q <= wr && grp_ok &&
                    (idx == `LSR_IDX_RELEASE ||
                     idx == `LSR_IDX_GAIN_TAP);
    end
  end

  assign nv_store = nv_store_q;

  // ==========================================================
  // Loss control registers
  // ==========================================================
  logic          los_dis_q;
  logic [DW-1:0] assert_lvl_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      los_dis_q    <= 1'b0;
      assert_lvl_q <= `LSR_RST_BYTE;
    end
    else if (wr)
    begin
      if (idx == `LSR_IDX_LOS_CTRL)
      begin
        los_dis_q <= wb_dat_i[`LSR_LOS_DIS_BIT];
      end
      if (idx == `LSR_IDX_ASSERT_LVL)
      begin
        assert_lvl_q <= wb_dat_i[DW-1:0];
      end
    end
  end

  // ==========================================================
  // Receive power scaling and loss comparator
  // ==========================================================
  logic [DW+5:0]       prod;
  logic [DW-1:0]       scaled;
  logic [`LSR_TAP_W:0] tap_mult;

  // A full multiply keeps every tap exact at the cost of a small multiplier
  assign tap_mult = `LSR_TAP_FULL - {1'b0, gain_tap_q};
  assign prod     = {{(`LSR_TAP_W+1){1'b0}}, receive_power_input} *
                    {{DW{1'b0}}, tap_mult};
  assign scaled = (gain_tap_q == '0) ? receive_power_input
                : prod[DW+`LSR_TAP_SHIFT-1:`LSR_TAP_SHIFT];

  logic los_q;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      los_q <= 1'b0;
    end
    else if (los_dis_q)
    begin
      // Release level unused while disabled
      los_q <= 1'b0;
    end
    else if (!los_q && (scaled < assert_lvl_q))
    begin
      los_q <= 1'b1;
    end
    else if (los_q && (scaled > release_q))
    begin
      los_q <= 1'b0;
    end
  end

  assign signal_loss_output = los_q;

  // ==========================================================
  // Event capture and interrupt
  // ==========================================================
  logic [`LSR_NUM_EV-1:0] ev_now;
  logic [`LSR_NUM_EV-1:0] ev_prev_q;
  logic [`LSR_NUM_EV-1:0] ev_rise;
  logic [`LSR_NUM_EV-1:0] ist_q;
  logic [`LSR_NUM_EV-1:0] imask_q;
  logic [`LSR_NUM_EV-1:0] w1c;
  logic                   irq_q;

  assign ev_now[lsr_pkg::LSR_EV_LOS]  = los_q;
  assign ev_now[lsr_pkg::LSR_EV_RXF]  = faults.rx_power && !los_dis_q;
  assign ev_now[lsr_pkg::LSR_EV_BIAS] = faults.bias_current;
  assign ev_now[lsr_pkg::LSR_EV_TXF]  = faults.tx_power;
  assign ev_now[lsr_pkg::LSR_EV_APC]  = faults.loop_saturation;

  assign w1c = (wr && idx == `LSR_IDX_IRQ_STAT) ?
               wb_dat_i[`LSR_NUM_EV-1:0] : `LSR_RST_EV;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ev_prev_q <= `LSR_RST_EV;
    end
    else
    begin
      ev_prev_q <= ev_now;
    end
  end

  // A rising event in the cycle of its clear keeps the bit set
  genvar g;
  generate
    for (g = 0; g < `LSR_NUM_EV; g++)
    begin : g_ev
      assign ev_rise[g] = ev_now[g] && !ev_prev_q[g];

      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          ist_q[g] <= 1'b0;
        end
        else if (ev_rise[g])
        begin
          ist_q[g] <= 1'b1;
        end
        else if (w1c[g])
        begin
          ist_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      imask_q <= `LSR_RST_EV;
    end
    else if (wr && idx == `LSR_IDX_IRQ_MASK)
    begin
      imask_q <= wb_dat_i[`LSR_NUM_EV-1:0];
    end
  end

  // Lags the status bits by one cycle so the pin comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ist_q & imask_q);
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // Status byte
  // ==========================================================
  logic [7:0] status;

  always_comb
  begin
    status                   = `LSR_RST_BYTE;
    status[`LSR_ST_RSVD]     = 1'b0;
    status[`LSR_ST_LASER_EN] = laser_enable;
    status[`LSR_ST_RX_FLT]   = faults.rx_power;
    status[`LSR_ST_INT]      = irq_q;
    status[`LSR_ST_APC_SAT]  = faults.loop_saturation;
    status[`LSR_ST_BIAS_FLT] = faults.bias_current;
    status[`LSR_ST_TX_FLT]   = faults.tx_power;
    status[`LSR_ST_RATE_SEL] = rsel_q;
  end

  // ==========================================================
  // Read mux and acknowledge
  // ==========================================================
  logic [31:0] rd;

  // Reads have no side effects on any state
  always_comb
  begin
    rd = 32'h0000_0000;
    if (grp_ok)
    begin
      case (idx)
        `LSR_IDX_MOD_DRIVE:  rd[DW-1:0] = modulation_drive_value;
        `LSR_IDX_FAULT_STAT: rd[7:0] = status;
        `LSR_IDX_RELEASE:    rd[DW-1:0] = release_q;
        `LSR_IDX_GAIN_TAP:   rd[`LSR_TAP_W-1:0] = gain_tap_q;
        `LSR_IDX_LOS_CTRL:   rd[`LSR_LOS_DIS_BIT] = los_dis_q;
        `LSR_IDX_ASSERT_LVL: rd[DW-1:0] = assert_lvl_q;
        `LSR_IDX_IRQ_STAT:   rd[`LSR_NUM_EV-1:0] = ist_q;
        `LSR_IDX_IRQ_MASK:   rd[`LSR_NUM_EV-1:0] = imask_q;
        default:             rd = 32'h0000_0000;
      endcase
    end
  end

  logic        ack_q;
  logic [31:0] dat_q;

  // Every access, mapped or not, is answered; refused ones read zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req;
      dat_q <= (req && !wb_we_i) ? rd : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

endmodule
`default_nettype wire

// file: verif/lsr_regs_monitor.sv
`default_nettype none
module lsr_regs_monitor #(
  parameter int unsigned DW = 8
) (
  input wire logic                 core_clk,
  input wire logic                 reset,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic                 oem_access_ok,
  input wire logic [DW-1:0]        modulation_drive_value,
  input wire logic                 laser_enable,
  input wire lsr_pkg::lsr_faults_t faults,
  input wire logic                 nv_store,
  input wire logic                 signal_loss_output,
  input wire logic                 irq
);
  timeunit 1ns;
  timeprecision 1ps;
  lsr_pkg::lsr_faults_t flt_q;

  always_ff @(posedge core_clk) flt_q <= faults;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // ==========================================
  // Bus steps
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence read_s(a);
    wb_ack_o && !wb_we_i && wb_adr_i == a && $past(oem_access_ok);
  endsequence

  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over two cycles");
  ack_next_a: assert property (taken_s |=> wb_ack_o)
    else $error("request not answered next cycle");
  refused_zero_a: assert property (wb_ack_o && !wb_we_i && !$past(oem_access_ok)
    && wb_adr_i inside {8'h54, 8'h58, 8'h5C, 8'h60} |-> wb_dat_o == 32'h0)
    else $error("refused read gave data");
  mod_read_a: assert property (read_s(8'h54) |->
    wb_dat_o[DW-1:0] == $past(modulation_drive_value)) else $error("drive readback wrong");
  stat_top_a: assert property (read_s(8'h58) |->
    !wb_dat_o[7] && wb_dat_o[6] == $past(laser_enable)) else $error("status top bits wrong");
  stat_flags_a: assert property (read_s(8'h58) |-> wb_dat_o[5:1] ==
    {flt_q.rx_power, $past(irq), flt_q.loop_saturation, flt_q.bias_current, flt_q.tx_power})
    else $error("status flags wrong");
  nv_pulse_a: assert property (nv_store |=> !nv_store)
    else $error("store pulse too long");
  nv_write_a: assert property (taken_s ##0 (wb_we_i && wb_sel_i[0] && oem_access_ok
    && wb_adr_i inside {8'h5C, 8'h60}) |-> ##[1:2] nv_store) else $error("no store pulse");
  ro_write_a: assert property (taken_s ##0 (wb_we_i && wb_adr_i inside {8'h54, 8'h58})
    |=> !nv_store [*2]) else $error("read-only write stored");
  quiet_reset_a: assert property ($fell(reset) |-> !signal_loss_output && !irq)
    else $error("outputs set after reset");
endmodule
`default_nettype wire

// file: verif/lsr_host.sv
`default_nettype none
module lsr_host (
  input  wire logic        core_clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       sel,
  output logic [7:0]       adr,
  output logic [31:0]      wdat
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {cyc, stb, we, sel, adr, wdat} = '0;
  end

  // Released lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hF, a, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we, sel, adr, wdat} <= {2'b00, ~w, 4'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, oem_access_ok;
  logic                 laser_enable, rate_select_output, nv_store, signal_loss_output, irq;
  logic [7:0]           wb_adr_i, modulation_drive_value, receive_power_input, nv_release_image;
  logic [3:0]           wb_sel_i;
  logic [4:0]           nv_gain_image;
  logic [31:0]          wb_dat_i, wb_dat_o, got;
  lsr_pkg::lsr_faults_t faults;
  int                   failures, cmp_count;
  logic [15:0]          rows [9] = '{16'h54A5, 16'h5863, 16'h5C3C, 16'h6004, 16'h8000,
                                     16'h8400, 16'h880A, 16'h8C00, 16'hFC00};

  lsr_regs dut (.core_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .oem_access_ok, .modulation_drive_value, .laser_enable,
    .faults, .rate_select_output, .receive_power_input, .nv_release_image, .nv_gain_image,
    .nv_store, .signal_loss_output, .irq);
  lsr_host host (.core_clk, .ack(wb_ack_o), .rdat(wb_dat_o), .cyc(wb_cyc_i), .stb(wb_stb_i),
    .we(wb_we_i), .sel(wb_sel_i), .adr(wb_adr_i), .wdat(wb_dat_i));

  // ==========================================
  // Checks
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, {24'h0, d}, got);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 32'h0, got);
    chk({24'h0, e}, got, "read data");
  endtask
  task automatic lp(input logic [7:0] v, input logic el, input logic ei);
    @(posedge core_clk) receive_power_input <= v;
    repeat (4) @(posedge core_clk);
    chk({31'h0, el}, {31'h0, signal_loss_output}, "loss output");
    chk({31'h0, ei}, {31'h0, irq}, "irq");
  endtask
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================
  // Stimulus
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #40000;
    failures++;
    end_sim();
  end
  initial
  begin
    {reset, oem_access_ok, laser_enable, rate_select_output} = 4'hF;
    {modulation_drive_value, receive_power_input, faults} = {8'hA5, 8'hFF, 4'h0};
    {nv_release_image, nv_gain_image} = {8'h3C, 5'h04};
    failures = 0;
    cmp_count = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk) faults <= 4'hA;
    repeat (4) @(posedge core_clk);
    foreach (rows[i]) rd(rows[i][15:8], rows[i][7:0]);
    @(posedge core_clk) oem_access_ok <= 1'b0;
    wr(8'h5C, 8'hEE);
    rd(8'h54, 8'h00);
    @(posedge core_clk) oem_access_ok <= 1'b1;
    rd(8'h5C, 8'h3C);
    wr(8'h58, 8'hFF);
    wr(8'h54, 8'h00);
    rd(8'h58, 8'h63);
    rd(8'h54, 8'hA5);
    // Drive the status sources to their other levels; the pin needs its synchroniser lag
    @(posedge core_clk) {laser_enable, rate_select_output, faults} <= 6'h05;
    repeat (2) @(posedge core_clk);
    rd(8'h58, 8'h0C);
    rd(8'h88, 8'h1E);
    @(posedge core_clk) {laser_enable, rate_select_output, faults} <= 6'h3A;
    wr(8'h60, 8'hFF);
    rd(8'h60, 8'h1F);
    wr(8'h88, 8'hFF);
    wr(8'h8C, 8'h01);
    wr(8'h60, 8'h00);
    wr(8'h5C, 8'h80);
    wr(8'h84, 8'h40);
    lp(8'h30, 1'b1, 1'b1);
    lp(8'h60, 1'b1, 1'b1);
    lp(8'h90, 1'b0, 1'b1);
    wr(8'h8C, 8'h00);
    lp(8'h90, 1'b0, 1'b0);
    wr(8'h88, 8'h01);
    wr(8'h8C, 8'h01);
    lp(8'h90, 1'b0, 1'b0);
    wr(8'h60, 8'h10);
    lp(8'h70, 1'b1, 1'b1);
    lp(8'hFF, 1'b1, 1'b1);
    wr(8'h60, 8'h00);
    lp(8'hFF, 1'b0, 1'b1);
    wr(8'h60, 8'h1F);
    lp(8'hFF, 1'b1, 1'b1);
    rd(8'h58, 8'h73);
    wr(8'h80, 8'h01);
    lp(8'h30, 1'b0, 1'b1);
    lp(8'hFF, 1'b0, 1'b1);
    wr(8'h88, 8'hFF);
    @(posedge core_clk) faults <= 4'h0;
    @(posedge core_clk) faults <= 4'h8;
    lp(8'h30, 1'b0, 1'b0);
    rd(8'h88, 8'h00);
    @(posedge core_clk) nv_release_image <= 8'h77;
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h5C, 8'h77);
    rd(8'h60, 8'h04);
    rd(8'h84, 8'h00);
    end_sim();
  end
endmodule

bind lsr_regs lsr_regs_monitor #(.DW(DW)) mon (.core_clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .oem_access_ok,
  .modulation_drive_value, .laser_enable, .faults, .nv_store, .signal_loss_output, .irq);
`default_nettype wire
